/* tb/line_monitor.sv */
`timescale 1ns/1ps
// Line-side partner: a link partner that measures pulse spacing on the wire
module line_monitor (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic mdix_pulse,
  input wire logic flp_pulse,
  output int mdix_gap,
  output int flp_gap,
  output int mdix_cnt,
  output int flp_cnt
);
  int mdix_age;
  int flp_age;
  // Age counters restart on each pulse; the gap is the spacing in cycles
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mdix_age <= 0;
      flp_age <= 0;
      mdix_gap <= 0;
      flp_gap <= 0;
      mdix_cnt <= 0;
      flp_cnt <= 0;
    end else begin
      mdix_age <= mdix_pulse ? 1 : mdix_age + 1;
      flp_age <= flp_pulse ? 1 : flp_age + 1;
      if (mdix_pulse) begin
        mdix_gap <= mdix_age;
        mdix_cnt <= mdix_cnt + 1;
      end
      if (flp_pulse) begin
        flp_gap <= flp_age;
        flp_cnt <= flp_cnt + 1;
      end
    end
  end
endmodule : line_monitor

/* tb/phy_crossover_config_bench.sv */
`timescale 1ns/1ps
module phy_crossover_config_bench;
  localparam logic [4:0] A_CTL = xover_pkg::BASIC_CONTROL_OFS;
  localparam logic [4:0] A_CFG = xover_pkg::VENDOR_CONFIG_ONE_OFS;
  localparam logic [4:0] A_MODE = xover_pkg::EXPANDED_ACCESS_MODE_OFS;
  localparam logic [4:0] A_DATA = xover_pkg::EXPANDED_MEMORY_DATA_OFS;
  localparam logic [4:0] A_PTR = xover_pkg::EXPANDED_MEMORY_POINTER_OFS;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic compat_strap_in = 1'b1;
  logic compat_strap_pulled = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic reg_ack, compat_mode, auto_xover_en, pair_crossed, mdix_pulse, flp_pulse, powered_down, int_out, p;
  int fail_count = 0;
  int num_checks = 0;
  int mdix_gap, flp_gap, mdix_cnt, flp_cnt, n;

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  // Short pulse periods keep the run brief
  phy_crossover_config #(.MDIX_CYC(20), .FLP_CYC(16)) dut_u (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .compat_strap_in(compat_strap_in), .compat_strap_pulled(compat_strap_pulled),
    .compat_mode(compat_mode), .auto_xover_en(auto_xover_en), .pair_crossed(pair_crossed),
    .mdix_pulse(mdix_pulse), .flp_pulse(flp_pulse), .powered_down(powered_down), .int_out(int_out));

  line_monitor mon_u (.mclk(mclk), .rst_n(rst_n), .mdix_pulse(mdix_pulse), .flp_pulse(flp_pulse),
    .mdix_gap(mdix_gap), .flp_gap(flp_gap), .mdix_cnt(mdix_cnt), .flp_cnt(flp_cnt));

  task chk16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk16

  task chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk1

  task chkn(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      fail_count++;
      $display("BAD %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chkn

  // Bounded wait; 16-bit data writes answer one cycle later than the rest
  task wait_ack;
    int i;
    for (i = 0; i < 4; i++) begin
      #1;
      if (reg_ack === 1'b1) break;
      @(posedge mclk);
    end
    if (i == 4) begin
      fail_count++;
      $display("BAD %0t no acknowledge", $time);
    end
  endtask : wait_ack

  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    wait_ack;
  endtask : wr

  task rchk(input logic [4:0] a, input logic [15:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    wait_ack;
    chk16(reg_rdata, exp);
  endtask : rchk

  // Strap is sampled just after reset release, so it is set first
  task do_reset(input logic pulled, input logic lvl);
    @(posedge mclk);
    compat_strap_pulled <= pulled;
    compat_strap_in <= lvl;
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask : do_reset

  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  // Watchdog: the tests need about 250 cycles
  initial begin
    #100000;
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    finish_test;
  end

  initial begin
    do_reset(1'b0, 1'b1);
    chk1(compat_mode, 1'b0);
    chk1(auto_xover_en, 1'b1);
    chk1(int_out, 1'b0);
    rchk(A_CTL, 16'h0000);
    wr(5'h05, 16'hffff);
    rchk(5'h05, 16'h0000);
    repeat (60) @(posedge mclk);
    chkn(mdix_gap, 20);
    chkn(flp_gap, 16);
    wr(A_CFG, 16'h0400);
    chk1(compat_mode, 1'b1);
    rchk(A_CFG, 16'h0400);
    wr(A_CFG, 16'h0000);
    chk1(compat_mode, 1'b0);
    $display("test reset_and_strap done");
    do_reset(1'b1, 1'b1);
    chk1(compat_mode, 1'b1);
    wr(A_CTL, 16'h0800);
    chk1(powered_down, 1'b1);
    // A pulse launched on the power-down edge still reaches the monitor one cycle later
    repeat (2) @(posedge mclk);
    #1;
    n = flp_cnt;
    repeat (40) @(posedge mclk);
    chkn(flp_cnt, n);
    wr(A_MODE, 16'h000d);
    wr(A_PTR, 16'h808b);
    wr(A_DATA, 16'h0001);
    chk1(auto_xover_en, 1'b0);
    chk1(int_out, 1'b1);
    rchk(A_PTR, 16'h808c);
    wr(A_PTR, 16'h808b);
    rchk(A_DATA, 16'h0001);
    rchk(A_PTR, 16'h808c);
    rchk(A_CTL, 16'h0800);
    chk1(int_out, 1'b0);
    wr(A_CTL, 16'h0000);
    chk1(powered_down, 1'b0);
    // The pair is picked one cycle after power-up, so take the reference after that
    repeat (2) @(posedge mclk);
    #1;
    n = mdix_cnt;
    p = pair_crossed;
    repeat (60) @(posedge mclk);
    chkn(mdix_cnt, n);
    chk1(pair_crossed, p);
    chkn(flp_gap, 16);
    $display("test crossover_disable done");
    // Byte store in 8-bit mode, then pair split in 16-bit mode
    wr(A_PTR, 16'h0010);
    wr(A_DATA, 16'hab12);
    rchk(A_PTR, 16'h0011);
    wr(A_PTR, 16'h0010);
    rchk(A_DATA, 16'h0012);
    wr(A_MODE, 16'h0006);
    wr(A_PTR, 16'h0020);
    wr(A_DATA, 16'h3456);
    rchk(A_PTR, 16'h0022);
    wr(A_PTR, 16'h0020);
    rchk(A_DATA, 16'h0034);
    rchk(A_DATA, 16'h0056);
    wr(A_MODE, 16'h000d);
    wr(A_PTR, 16'h808b);
    wr(A_DATA, 16'h0000);
    chk1(auto_xover_en, 1'b1);
    $display("test expanded_memory done");
    finish_test;
  end
endmodule : phy_crossover_config_bench

/* verilog/phy_crossover_config.sv */
// Function
// - Mode 000D routes data port to memory
// - Writing 0001 there disables automatic crossover
// - Auto crossover emits pulses every 150 us
// - Fast link pulses every 125 us
// - Crossover off: random pair at start
// - Compat mode from strap or bit 10
// - Interrupt is driven push-pull, either polarity
// - Floating strap takes internal default value
// - Pointer increments after each data access in expanded mode
// - 8-bit mode stores low byte only
`timescale 1ns/1ps
module phy_crossover_config #(
  parameter int MDIX_CYC = xover_pkg::MDIX_PERIOD_CYC,
  parameter int FLP_CYC = xover_pkg::FLP_PERIOD_CYC,
  parameter int MEM_AW = 6,
  parameter bit INT_ACTIVE_HIGH = 1'b1,
  parameter bit COMPAT_STRAP_DEFAULT = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_ack,
  input wire logic compat_strap_in,
  input wire logic compat_strap_pulled,
  output logic compat_mode,
  output logic auto_xover_en,
  output logic pair_crossed,
  output logic mdix_pulse,
  output logic flp_pulse,
  output logic powered_down,
  output logic int_out
);
  initial begin
    if (MEM_AW < 1 || MEM_AW > 14) $error("phy_crossover_config: MEM_AW out of range");
  end

  // Reset release through two flops
  logic rs1_r;
  logic rs2_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rs2_r <= rs1_r;
    end
  end
  logic srst_n;
  assign srst_n = rs2_r;

  // Strap pins come from outside, two flops before use
  // No reset here: the pair fills with the pin level during reset, so the one-shot latch never sees a stale zero
  logic [1:0] st1_r;
  logic [1:0] st2_r;
  always_ff @(posedge mclk) begin
    if (ce) begin
      st1_r <= {compat_strap_pulled, compat_strap_in};
      st2_r <= st1_r;
    end
  end

  logic [7:0] mem [2**MEM_AW];
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [15:0] vcfg_r, vcfg_nxt;
  logic [15:0] mode_r, mode_nxt;
  logic [15:0] ptr_r, ptr_nxt;
  logic [15:0] data_r, data_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic ack_r, ack_nxt;
  logic pend_r, pend_nxt;
  logic xdis_r, xdis_nxt;
  logic cross_r, cross_nxt;
  logic strap_r, strap_nxt;
  logic strap_done_r, strap_done_nxt;
  logic irq_r, irq_nxt;
  logic start_r, start_nxt;
  logic [15:0] lfsr_r, lfsr_nxt;
  logic mem_we;
  logic [MEM_AW-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic exp_on;
  logic data_acc;
  logic [7:0] rd_byte;
  logic pd_rise_clear;

  assign exp_on = (mode_r == xover_pkg::MODE_EXP_8BIT) || (mode_r == xover_pkg::MODE_EXP_16BIT);
  assign data_acc = (reg_wr || reg_rd) && !pend_r && reg_addr == xover_pkg::EXPANDED_MEMORY_DATA_OFS;
  // Crossover byte lives in its own flop so the line logic sees it directly
  assign rd_byte = (ptr_r == xover_pkg::XOVER_LOC) ? {7'h00, xdis_r} : mem[ptr_r[MEM_AW-1:0]];
  assign pd_rise_clear = ctrl_r[xover_pkg::POWER_DOWN_BIT];

  // Register file, expanded memory access and crossover state
  always_comb begin
    ctrl_nxt = ctrl_r;
    vcfg_nxt = vcfg_r;
    mode_nxt = mode_r;
    ptr_nxt = ptr_r;
    data_nxt = data_r;
    rdata_nxt = rdata_r;
    ack_nxt = 1'b0;
    pend_nxt = 1'b0;
    xdis_nxt = xdis_r;
    irq_nxt = irq_r;
    mem_we = 1'b0;
    mem_wa = ptr_r[MEM_AW-1:0];
    mem_wd = 8'h00;
    if (pend_r) begin
      // Second half of a 16-bit write: low byte to the next location
      mem_we = 1'b1;
      mem_wd = data_r[7:0];
      ptr_nxt = ptr_r + 16'h0001;
      ack_nxt = 1'b1;
    end else if (reg_wr) begin
      case (reg_addr)
        xover_pkg::BASIC_CONTROL_OFS: ctrl_nxt = reg_wdata;
        xover_pkg::VENDOR_CONFIG_ONE_OFS: vcfg_nxt = reg_wdata;
        xover_pkg::EXPANDED_ACCESS_MODE_OFS: mode_nxt = reg_wdata;
        xover_pkg::EXPANDED_MEMORY_POINTER_OFS: ptr_nxt = reg_wdata;
        xover_pkg::EXPANDED_MEMORY_DATA_OFS: begin
          data_nxt = reg_wdata;
          if (exp_on) begin
            mem_we = 1'b1;
            ptr_nxt = ptr_r + 16'h0001;
            if (mode_r == xover_pkg::MODE_EXP_16BIT) begin
              mem_wd = reg_wdata[15:8];
              pend_nxt = 1'b1;
            end else begin
              mem_wd = reg_wdata[7:0];
            end
          end
        end
        default: ;
      endcase
      ack_nxt = !(exp_on && mode_r == xover_pkg::MODE_EXP_16BIT && data_acc);
    end else if (reg_rd) begin
      case (reg_addr)
        xover_pkg::BASIC_CONTROL_OFS: rdata_nxt = ctrl_r;
        xover_pkg::VENDOR_CONFIG_ONE_OFS: rdata_nxt = vcfg_r;
        xover_pkg::EXPANDED_ACCESS_MODE_OFS: rdata_nxt = mode_r;
        xover_pkg::EXPANDED_MEMORY_POINTER_OFS: rdata_nxt = ptr_r;
        xover_pkg::EXPANDED_MEMORY_DATA_OFS: begin
          if (exp_on) begin
            rdata_nxt = {8'h00, rd_byte};
            ptr_nxt = ptr_r + 16'h0001;
          end else begin
            rdata_nxt = data_r;
          end
        end
        default: rdata_nxt = 16'h0000;
      endcase
      ack_nxt = 1'b1;
      if (reg_addr == xover_pkg::BASIC_CONTROL_OFS) irq_nxt = 1'b0;
    end
    // Crossover control byte write; the event flag set wins over a same-cycle clear
    if (mem_we && ((pend_r ? ptr_r : ptr_r) == xover_pkg::XOVER_LOC)) begin
      xdis_nxt = (mem_wd == 8'h01);
      if (mem_wd == 8'h01) irq_nxt = 1'b1;
    end
  end

  // Strap capture after release, random pair pick at each start while crossover is disabled
  always_comb begin
    strap_nxt = strap_r;
    strap_done_nxt = 1'b1;
    lfsr_nxt = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    cross_nxt = cross_r;
    start_nxt = pd_rise_clear;
    if (!strap_done_r) begin
      strap_nxt = st2_r[1] ? st2_r[0] : COMPAT_STRAP_DEFAULT;
    end
    if (start_r && !pd_rise_clear) begin
      // Leaving power-down is the start point for the pair choice
      if (xdis_r) cross_nxt = lfsr_r[0];
    end else if (!xdis_r && mdix_pulse) begin
      cross_nxt = !cross_r; // Auto crossover hunts by swapping pairs
    end
  end

  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      ctrl_r <= xover_pkg::BASIC_CONTROL_RST;
      vcfg_r <= xover_pkg::VENDOR_CONFIG_ONE_RST;
      mode_r <= xover_pkg::ACCESS_MODE_RST;
      ptr_r <= xover_pkg::POINTER_RST;
      data_r <= 16'h0000;
      rdata_r <= 16'h0000;
      ack_r <= 1'b0;
      pend_r <= 1'b0;
      xdis_r <= 1'b0;
      irq_r <= 1'b0;
      strap_r <= 1'b0;
      strap_done_r <= 1'b0;
      lfsr_r <= xover_pkg::LFSR_SEED;
      cross_r <= 1'b0;
      start_r <= 1'b1;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
      vcfg_r <= vcfg_nxt;
      mode_r <= mode_nxt;
      ptr_r <= ptr_nxt;
      data_r <= data_nxt;
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
      pend_r <= pend_nxt;
      xdis_r <= xdis_nxt;
      irq_r <= irq_nxt;
      strap_r <= strap_nxt;
      strap_done_r <= strap_done_nxt;
      lfsr_r <= lfsr_nxt;
      cross_r <= cross_nxt;
      start_r <= start_nxt;
    end
  end

  // Memory has no reset; contents are whatever the host loads
  always_ff @(posedge mclk) begin
    if (ce && mem_we) mem[mem_wa] <= mem_wd;
  end

  logic line_run;
  assign line_run = !ctrl_r[xover_pkg::POWER_DOWN_BIT];

  pulse_timer #(.PERIOD(MDIX_CYC)) u_mdix (
    .mclk(mclk),
    .rst_n(srst_n),
    .ce(ce),
    .run(line_run && !xdis_r),
    .pulse(mdix_pulse)
  );

  pulse_timer #(.PERIOD(FLP_CYC)) u_flp (
    .mclk(mclk),
    .rst_n(srst_n),
    .ce(ce),
    .run(line_run),
    .pulse(flp_pulse)
  );

  // Push-pull interrupt, driven both ways, never open drain
  assign int_out = INT_ACTIVE_HIGH ? irq_r : !irq_r;
  assign compat_mode = strap_r | vcfg_r[xover_pkg::COMPAT_MODE_BIT];
  assign auto_xover_en = !xdis_r;
  assign pair_crossed = cross_r;
  assign powered_down = ctrl_r[xover_pkg::POWER_DOWN_BIT];
  assign reg_rdata = rdata_r;
  assign reg_ack = ack_r;

  xdis_set_a: assert property (@(posedge mclk) disable iff (!srst_n)
    ce && reg_wr && !pend_r && reg_addr == xover_pkg::EXPANDED_MEMORY_DATA_OFS && reg_wdata == 16'h0001
    && mode_r == xover_pkg::MODE_EXP_8BIT && ptr_r == xover_pkg::XOVER_LOC |=> !auto_xover_en)
    else $error("crossover not disabled by data write");
  ptr_inc_a: assert property (@(posedge mclk) disable iff (!srst_n)
    ce && reg_rd && !pend_r && exp_on && reg_addr == xover_pkg::EXPANDED_MEMORY_DATA_OFS
    |=> ptr_r == $past(ptr_r) + 16'h0001)
    else $error("pointer did not advance after data read");
  low_byte_a: assert property (@(posedge mclk) disable iff (!srst_n)
    mem_we && !pend_r && mode_r == xover_pkg::MODE_EXP_8BIT |-> mem_wd == reg_wdata[7:0])
    else $error("8-bit mode stored wrong byte");
  exp_gate_a: assert property (@(posedge mclk) disable iff (!srst_n)
    mem_we |-> exp_on || pend_r)
    else $error("memory written outside expanded mode");
  mdix_gap_a: assert property (@(posedge mclk) disable iff (!srst_n)
    ce && mdix_pulse |=> !mdix_pulse)
    else $error("crossover pulses back to back");
  mdix_off_a: assert property (@(posedge mclk) disable iff (!srst_n)
    !auto_xover_en && $past(!auto_xover_en) |-> !mdix_pulse)
    else $error("crossover pulse while disabled");
  pair_hold_a: assert property (@(posedge mclk) disable iff (!srst_n)
    !auto_xover_en && !start_r && $past(!auto_xover_en) && $past(!start_r) |-> $stable(pair_crossed))
    else $error("pair changed while crossover disabled");
  compat_a: assert property (@(posedge mclk) disable iff (!srst_n)
    vcfg_r[xover_pkg::COMPAT_MODE_BIT] |-> compat_mode)
    else $error("compat bit did not enable mode");
  int_drive_a: assert property (@(posedge mclk) disable iff (!srst_n)
    ce && mem_we && ptr_r == xover_pkg::XOVER_LOC && mem_wd == 8'h01 |=> int_out == INT_ACTIVE_HIGH)
    else $error("interrupt not driven active after crossover disable");
  pend_ack_a: assert property (@(posedge mclk) disable iff (!srst_n)
    ce && pend_r |=> reg_ack ##1 !pend_r)
    else $error("16-bit write not completed");
endmodule : phy_crossover_config

/* verilog/pulse_timer.sv */
`timescale 1ns/1ps
// Emits a one-cycle pulse every PERIOD enabled cycles while run is high
module pulse_timer #(
  parameter int PERIOD = 25000
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic run,
  output logic pulse
);
  localparam int CW = $clog2(PERIOD + 1);
  initial begin
    if (PERIOD < 2) $error("pulse_timer: PERIOD must be at least 2");
  end
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic pulse_r;
  logic pulse_nxt;

  // Restart from zero whenever run drops, so the first pulse is a full period late
  always_comb begin
    cnt_nxt = cnt_r;
    pulse_nxt = 1'b0;
    if (!run) begin
      cnt_nxt = '0;
    end else if (cnt_r == CW'(PERIOD - 1)) begin
      cnt_nxt = '0;
      pulse_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      pulse_r <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign pulse = pulse_r;
endmodule : pulse_timer

/* verilog/xover_pkg.sv */
package xover_pkg;
  // Management register offsets
  localparam logic [4:0] BASIC_CONTROL_OFS = 5'h00;
  localparam logic [4:0] VENDOR_CONFIG_ONE_OFS = 5'h10;
  localparam logic [4:0] EXPANDED_ACCESS_MODE_OFS = 5'h16;
  localparam logic [4:0] EXPANDED_MEMORY_DATA_OFS = 5'h1d;
  localparam logic [4:0] EXPANDED_MEMORY_POINTER_OFS = 5'h1e;
  // Field positions
  localparam int POWER_DOWN_BIT = 11;
  localparam int COMPAT_MODE_BIT = 10;
  localparam int XOVER_DIS_BIT = 0;
  // Access mode codes
  localparam logic [15:0] MODE_EXP_8BIT = 16'h000d;
  localparam logic [15:0] MODE_EXP_16BIT = 16'h0006;
  // Internal location of the crossover control byte
  localparam logic [15:0] XOVER_LOC = 16'h808b;
  // Reset values
  localparam logic [15:0] BASIC_CONTROL_RST = 16'h0000;
  localparam logic [15:0] VENDOR_CONFIG_ONE_RST = 16'h0000;
  localparam logic [15:0] ACCESS_MODE_RST = 16'h0000;
  localparam logic [15:0] POINTER_RST = 16'h0000;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int MDIX_PERIOD_US = 150;
  localparam int FLP_PERIOD_US = 125;
  localparam int FLP_TOL_US = 14;
  localparam int MDIX_PERIOD_CYC = MDIX_PERIOD_US * CLK_MHZ;
  localparam int FLP_PERIOD_CYC = FLP_PERIOD_US * CLK_MHZ;
endpackage : xover_pkg
